/* File: core/hd2_consts.svh */
/*
  Frame geometry constants for the two-pair line framer: bit positions,
  overhead indices, sync pattern and stuffing figures.
  Assumes it is included by bare name wherever a constant is used.
*/
`ifndef HD2_CONSTS_SVH
`define HD2_CONSTS_SVH
`define HD2_POS_W 13
`define HD2_OH_W 6
`define HD2_SYNC_WORD 14'h3972
`define HD2_SYNC_LEN 6'h0e
`define HD2_POS_FIRST 13'h0001
`define HD2_POS_SECOND 13'h0002
`define HD2_HEAD_LAST 13'h0010
`define HD2_RUN1_FIRST 13'h0011
`define HD2_RUN1_LAST 13'h06dc
`define HD2_GRP1_FIRST 13'h06dd
`define HD2_GRP1_LAST 13'h06e6
`define HD2_GRP1_OFF 13'h06cc
`define HD2_RUN2_FIRST 13'h06e7
`define HD2_RUN2_LAST 13'h0db2
`define HD2_GRP2_FIRST 13'h0db3
`define HD2_GRP2_LAST 13'h0dbc
`define HD2_GRP2_OFF 13'h0d98
`define HD2_RUN3_FIRST 13'h0dbd
`define HD2_RUN3_LAST 13'h1488
`define HD2_GRP3_FIRST 13'h1489
`define HD2_GRP3_LAST 13'h1492
`define HD2_GRP3_OFF 13'h1464
`define HD2_RUN4_FIRST 13'h1493
`define HD2_RUN4_LAST 13'h1b5e
`define HD2_STUFF_OFF 13'h1b30
`define HD2_STUFF_MAX 2'h2
`define HD2_BLK_LAST 8'h90
`define HD2_Z_N 48
`define HD2_Z_CORE 6'h08
`define HD2_Z_APP_N 40
`define HD2_EOC_N 13
`define HD2_CRC_N 6
`define HD2_REGEN_N 4
`define HD2_OH_RX_N 46
`define HD2_OH_LOSD 6'h0f
`define HD2_OH_FEBE 6'h10
`define HD2_OH_EOC1 6'h11
`define HD2_OH_EOC4 6'h14
`define HD2_OH_CRC1 6'h15
`define HD2_OH_CRC2 6'h16
`define HD2_OH_PWR1 6'h17
`define HD2_OH_PWR2 6'h18
`define HD2_OH_BPV 6'h19
`define HD2_OH_EOC5 6'h1a
`define HD2_OH_EOC6 6'h1b
`define HD2_OH_EOC9 6'h1e
`define HD2_OH_CRC3 6'h1f
`define HD2_OH_CRC4 6'h20
`define HD2_OH_HRP 6'h21
`define HD2_OH_REPA 6'h24
`define HD2_OH_EOC10 6'h25
`define HD2_OH_EOC13 6'h28
`define HD2_OH_CRC5 6'h29
`define HD2_OH_CRC6 6'h2a
`define HD2_OH_RTA 6'h2b
`define HD2_OH_IND 6'h2c
`define HD2_EOC_B5 4'h4
`define HD2_EOC_B6 4'h5
`define HD2_EOC_B10 4'h9
`define HD2_CRC_B1 3'h0
`define HD2_CRC_B3 3'h2
`define HD2_CRC_B5 3'h4
`endif

/* File: core/hd2_pkg.sv */
/*
  Types shared by the two-pair framer modules.
  Assumes nothing of its surroundings.
*/
package hd2_pkg;
  typedef logic [1:0] hd2_stuff_t;
  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_RUN = 1'b1
  } hd2_tx_state_t;
endpackage : hd2_pkg

/* File: core/hd2_ifs.sv */
/*
  Carriers between the framer's own modules: the position tracker link
  and the two-entry buffer's stream link.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface hd2_pos_if;
  logic advance;
  logic realign;
  logic [1:0] stuff_pairs;
  logic [12:0] pos;
  logic [5:0] oh_idx;
  logic [5:0] z_idx;
  logic is_data;
  logic is_zbit;
  logic is_last;
  modport track (input advance, realign, stuff_pairs,
    output pos, oh_idx, z_idx, is_data, is_zbit, is_last);
  modport user (output advance, realign, stuff_pairs,
    input pos, oh_idx, z_idx, is_data, is_zbit, is_last);
endinterface : hd2_pos_if

interface hd2_strm_if #(parameter int W = 3);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, data, input ready);
  modport snk (input valid, data, output ready);
endinterface : hd2_strm_if

/* File: core/hd2_pos_track.sv */
/*
  Frame position tracker: bit position, overhead index, payload block
  and aux overhead bit number of the current frame bit.
  Assumes the user advances once per frame bit.
*/
`timescale 1ns/1ns
`include "hd2_consts.svh"
module hd2_pos_track (
  input wire logic clk_in,
  input wire logic rst_n_in,
  hd2_pos_if.track pif
);
  import hd2_pkg::*;
  logic [12:0] pos, next_pos;
  logic [7:0] blk_bit, next_blk_bit;
  logic [5:0] z_cnt, next_z_cnt;
  logic [1:0] stuff, next_stuff;
  logic in_run;
  logic [12:0] last_pos;

  always_comb
  begin
    in_run = (pos >= `HD2_RUN1_FIRST && pos <= `HD2_RUN1_LAST) ||
      (pos >= `HD2_RUN2_FIRST && pos <= `HD2_RUN2_LAST) ||
      (pos >= `HD2_RUN3_FIRST && pos <= `HD2_RUN3_LAST) ||
      (pos >= `HD2_RUN4_FIRST && pos <= `HD2_RUN4_LAST);
    pif.pos = pos;
    pif.z_idx = z_cnt;
    // block opens with its aux overhead bit
    pif.is_zbit = in_run && (blk_bit == 8'h00);
    pif.is_data = in_run && (blk_bit != 8'h00);
    if (pos <= `HD2_HEAD_LAST)
      pif.oh_idx = pos[5:0];
    else if (pos >= `HD2_GRP1_FIRST && pos <= `HD2_GRP1_LAST)
      pif.oh_idx = 6'(pos - `HD2_GRP1_OFF);
    else if (pos >= `HD2_GRP2_FIRST && pos <= `HD2_GRP2_LAST)
      pif.oh_idx = 6'(pos - `HD2_GRP2_OFF);
    else if (pos >= `HD2_GRP3_FIRST && pos <= `HD2_GRP3_LAST)
      pif.oh_idx = 6'(pos - `HD2_GRP3_OFF);
    else if (pos > `HD2_RUN4_LAST)
      pif.oh_idx = 6'(pos - `HD2_STUFF_OFF);
    else
      pif.oh_idx = 6'h00;
    last_pos = `HD2_RUN4_LAST + {10'h000, stuff, 1'b0};
    pif.is_last = (pos == last_pos);
    next_pos = pos;
    next_blk_bit = blk_bit;
    next_z_cnt = z_cnt;
    next_stuff = stuff;
    if (pif.advance)
    begin
      if (pos == `HD2_POS_FIRST || pif.realign)
        next_stuff = (pif.stuff_pairs > `HD2_STUFF_MAX) ? `HD2_STUFF_MAX : pif.stuff_pairs;
      if (pif.realign)
      begin
        next_pos = `HD2_POS_SECOND;
        next_blk_bit = 8'h00;
        next_z_cnt = 6'h00;
      end
      else if (pif.is_last)
      begin
        next_pos = `HD2_POS_FIRST;
        next_blk_bit = 8'h00;
        next_z_cnt = 6'h00;
      end
      else
      begin
        next_pos = pos + 13'h0001;
        if (in_run)
        begin
          if (blk_bit == `HD2_BLK_LAST)
          begin
            next_blk_bit = 8'h00;
            next_z_cnt = z_cnt + 6'h01;
          end
          else
            next_blk_bit = blk_bit + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      pos <= `HD2_POS_FIRST;
      blk_bit <= 8'h00;
      z_cnt <= 6'h00;
      stuff <= 2'h1;
    end
    else
    begin
      pos <= next_pos;
      blk_bit <= next_blk_bit;
      z_cnt <= next_z_cnt;
      stuff <= next_stuff;
    end
  end
endmodule : hd2_pos_track

/* File: core/hd2_buf2.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes the drain side may stall at any time.
*/
`timescale 1ns/1ns
module hd2_buf2 #(parameter int W = 3) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  hd2_strm_if.snk up,
  hd2_strm_if.src dn
);
  import hd2_pkg::*;
  logic [W-1:0] mem [0:1];
  logic [W-1:0] next_mem [0:1];
  logic wp, next_wp, rp, next_rp;
  logic [1:0] cnt, next_cnt;
  logic push, pop;

  if (W < 1)
    $error("hd2_buf2: width must be at least one");

  always_comb
  begin
    up.ready = (cnt != 2'h2);
    dn.valid = (cnt != 2'h0);
    dn.data = mem[rp];
    push = up.valid && up.ready;
    pop = dn.valid && dn.ready;
    next_mem = mem;
    next_wp = wp;
    next_rp = rp;
    if (push)
    begin
      next_mem[wp] = up.data;
      next_wp = !wp;
    end
    if (pop)
      next_rp = !rp;
    next_cnt = cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      mem[0] <= '0;
      mem[1] <= '0;
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end
    else
    begin
      mem <= next_mem;
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end
endmodule : hd2_buf2

/* File: core/hd2_framer.sv */
/*
  Two-pair line frame bit mapper: builds the pre-scrambler frame for each
  pair and takes apart the descrambled frame of each pair.
  Assumes a scrambler after LINE_* and a descrambler plus sync search
  before RX_*; stuffing decision, CRC and eoc content come from outside.
*/
`timescale 1ns/1ns
`include "hd2_consts.svh"
// Contract
// - frame built before scrambling; received frame read after descrambling
// - same geometry both ways; overhead meaning depends on direction
// - positions unassigned in current direction are sent as one
// - every pair uses the identical bit position assignment
// - power status bits 1763-1764 sent only by remote toward central
// - sync in bits 1-14, bit 15 far-end signal loss, 16 block error
// - payload runs 17-1756, 1767-3506, 3517-5256, 5267-7006 with aux bits
// - bits 3513-3516 carry regenerator present, errors and alarm
// - sync word is two consecutive seven-symbol Barker codes
// - frame ends with zero, one or two stuffing pairs: 7006-7010 bits
// - first eight aux overhead bits reserved and sent as one
module hd2_framer #(parameter int NUM_PAIRS = 2) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic DIR_REMOTE_IN,
  input wire logic REGEN_IN,
  input wire logic ENABLE_IN,
  input wire hd2_pkg::hd2_stuff_t STUFF_PAIRS_IN,
  input wire logic LOSD_IN,
  input wire logic [NUM_PAIRS-1:0] FEBE_IN,
  input wire logic [NUM_PAIRS-1:0] BPV_IN,
  input wire logic [NUM_PAIRS-1:0][`HD2_CRC_N-1:0] CRC_IN,
  input wire logic [`HD2_EOC_N-1:0] EOC_IN,
  input wire logic [1:0] UNIT_POWER_STATUS_IN,
  input wire logic REMOTE_ALARM_IN,
  input wire logic READY_TO_RECEIVE_IN,
  input wire logic [`HD2_REGEN_N-1:0] REGEN_BITS_IN,
  input wire logic [NUM_PAIRS-1:0][`HD2_Z_APP_N-1:0] AUX_OVERHEAD_IN,
  input wire logic PAYLOAD_VALID_IN,
  output logic PAYLOAD_READY_OUT,
  input wire logic [NUM_PAIRS-1:0] PAYLOAD_DATA_IN,
  output logic LINE_VALID_OUT,
  input wire logic LINE_READY_IN,
  output logic [NUM_PAIRS-1:0] LINE_BIT_OUT,
  output logic LINE_FIRST_OUT,
  output logic FRAME_ACTIVE_OUT,
  input wire logic RX_VALID_IN,
  input wire logic RX_FIRST_IN,
  input wire logic [NUM_PAIRS-1:0] RX_BIT_IN,
  output logic RX_DATA_VALID_OUT,
  output logic [NUM_PAIRS-1:0] RX_DATA_OUT,
  output logic [NUM_PAIRS-1:0][`HD2_OH_RX_N-1:0] RX_OVERHEAD_OUT,
  output logic [NUM_PAIRS-1:0][`HD2_Z_N-1:0] RX_AUX_OVERHEAD_OUT,
  output logic [NUM_PAIRS-1:0] RX_SYNC_ERR_OUT,
  output logic RX_FRAME_DONE_OUT
);
  import hd2_pkg::*;
  // a literal cannot be bit-selected, so the pattern lives in a constant
  localparam logic [13:0] sync_pat = `HD2_SYNC_WORD;

  hd2_pos_if tpos ();
  hd2_pos_if rpos ();
  hd2_strm_if #(.W(NUM_PAIRS + 1)) tx_up ();
  hd2_strm_if #(.W(NUM_PAIRS + 1)) tx_dn ();

  hd2_tx_state_t state, next_state;
  logic [NUM_PAIRS-1:0] tx_bit;
  logic eoc_hit, crc_hit;
  logic [3:0] eoc_sel;
  logic [2:0] crc_sel;
  logic [3:0] sync_sel;
  logic [5:0] z_app;
  logic tx_send;
  logic [5:0] rx_idx;
  logic rx_oh, rx_data, rx_zbit;
  logic rx_dv, next_rx_dv, rx_done, next_rx_done;

  if (NUM_PAIRS < 1)
    $error("hd2_framer: at least one pair needed");

  hd2_pos_track u_tx_track (
    .clk_in(CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .pif(tpos.track)
  );

  hd2_pos_track u_rx_track (
    .clk_in(CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .pif(rpos.track)
  );

  // stall on the line side backs up into the payload handshake
  hd2_buf2 #(.W(NUM_PAIRS + 1)) u_tx_buf (
    .clk_in(CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .up(tx_up.snk),
    .dn(tx_dn.src)
  );

  // field selectors depend on position only, shared by all pairs
  always_comb
  begin
    eoc_hit = 1'b1;
    eoc_sel = 4'h0;
    crc_hit = 1'b1;
    crc_sel = 3'h0;
    if (tpos.oh_idx >= `HD2_OH_EOC1 && tpos.oh_idx <= `HD2_OH_EOC4)
      eoc_sel = 4'(tpos.oh_idx - `HD2_OH_EOC1);
    else if (tpos.oh_idx == `HD2_OH_EOC5)
      eoc_sel = `HD2_EOC_B5;
    else if (tpos.oh_idx >= `HD2_OH_EOC6 && tpos.oh_idx <= `HD2_OH_EOC9)
      eoc_sel = 4'(tpos.oh_idx - `HD2_OH_EOC6) + `HD2_EOC_B6;
    else if (tpos.oh_idx >= `HD2_OH_EOC10 && tpos.oh_idx <= `HD2_OH_EOC13)
      eoc_sel = 4'(tpos.oh_idx - `HD2_OH_EOC10) + `HD2_EOC_B10;
    else
      eoc_hit = 1'b0;
    if (tpos.oh_idx == `HD2_OH_CRC1 || tpos.oh_idx == `HD2_OH_CRC2)
      crc_sel = 3'(tpos.oh_idx - `HD2_OH_CRC1) + `HD2_CRC_B1;
    else if (tpos.oh_idx == `HD2_OH_CRC3 || tpos.oh_idx == `HD2_OH_CRC4)
      crc_sel = 3'(tpos.oh_idx - `HD2_OH_CRC3) + `HD2_CRC_B3;
    else if (tpos.oh_idx == `HD2_OH_CRC5 || tpos.oh_idx == `HD2_OH_CRC6)
      crc_sel = 3'(tpos.oh_idx - `HD2_OH_CRC5) + `HD2_CRC_B5;
    else
      crc_hit = 1'b0;
    // double barker, first bit sent from the top
    sync_sel = 4'(`HD2_SYNC_LEN - tpos.oh_idx);
    z_app = tpos.z_idx - `HD2_Z_CORE;
  end

  for (genvar p = 0; p < NUM_PAIRS; p++)
  begin : g_tx_pair
    always_comb
    begin
      tx_bit[p] = 1'b1;
      if (tpos.is_data)
        tx_bit[p] = PAYLOAD_DATA_IN[p];
      else if (tpos.is_zbit)
      begin
        // core-reserved aux bits forced to one
        if (tpos.z_idx >= `HD2_Z_CORE)
          tx_bit[p] = AUX_OVERHEAD_IN[p][z_app];
      end
      else if (eoc_hit)
        tx_bit[p] = EOC_IN[eoc_sel];
      else if (crc_hit)
        tx_bit[p] = CRC_IN[p][crc_sel];
      else if (tpos.oh_idx != 6'h00 && tpos.oh_idx <= `HD2_SYNC_LEN)
        tx_bit[p] = sync_pat[sync_sel];
      else
      begin
        case (tpos.oh_idx)
          `HD2_OH_LOSD: tx_bit[p] = LOSD_IN;
          `HD2_OH_FEBE: tx_bit[p] = FEBE_IN[p];
          `HD2_OH_PWR1: tx_bit[p] = DIR_REMOTE_IN ? UNIT_POWER_STATUS_IN[0] : 1'b1;
          `HD2_OH_PWR2: tx_bit[p] = DIR_REMOTE_IN ? UNIT_POWER_STATUS_IN[1] : 1'b1;
          `HD2_OH_BPV: tx_bit[p] = BPV_IN[p];
          `HD2_OH_RTA: tx_bit[p] = DIR_REMOTE_IN ? REMOTE_ALARM_IN : 1'b1;
          `HD2_OH_IND: tx_bit[p] = READY_TO_RECEIVE_IN;
          default:
          begin
            // regenerator bits, driven only when acting as one
            if (REGEN_IN && tpos.oh_idx >= `HD2_OH_HRP && tpos.oh_idx <= `HD2_OH_REPA)
              tx_bit[p] = REGEN_BITS_IN[2'(tpos.oh_idx - `HD2_OH_HRP)];
          end
        endcase
      end
    end
  end

  // bits leave here unscrambled, scrambler sits downstream
  always_comb
  begin
    tx_send = (state == TX_RUN) && (!tpos.is_data || PAYLOAD_VALID_IN);
    tx_up.valid = tx_send;
    tx_up.data = {tpos.pos == `HD2_POS_FIRST, tx_bit};
    PAYLOAD_READY_OUT = (state == TX_RUN) && tpos.is_data && tx_up.ready;
    tpos.advance = tx_send && tx_up.ready;
    tpos.realign = 1'b0;
    tpos.stuff_pairs = STUFF_PAIRS_IN;
    tx_dn.ready = LINE_READY_IN;
    LINE_VALID_OUT = tx_dn.valid;
    LINE_BIT_OUT = tx_dn.data[NUM_PAIRS-1:0];
    LINE_FIRST_OUT = tx_dn.data[NUM_PAIRS];
    FRAME_ACTIVE_OUT = (state == TX_RUN);
    next_state = state;
    case (state)
      TX_IDLE:
        if (ENABLE_IN)
          next_state = TX_RUN;
      TX_RUN:
        // disable takes effect only at a frame boundary
        if (tpos.advance && tpos.is_last && !ENABLE_IN)
          next_state = TX_IDLE;
      default:
        next_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RST_N_IN)
      state <= TX_IDLE;
    else
      state <= next_state;
  end

  // receive side reads the descrambled stream only
  always_comb
  begin
    rpos.advance = RX_VALID_IN;
    rpos.realign = RX_FIRST_IN;
    // longest frame; the next sync marker realigns earlier frames
    rpos.stuff_pairs = `HD2_STUFF_MAX;
    rx_idx = RX_FIRST_IN ? 6'h01 : rpos.oh_idx;
    rx_data = RX_VALID_IN && !RX_FIRST_IN && rpos.is_data;
    rx_zbit = RX_VALID_IN && !RX_FIRST_IN && rpos.is_zbit;
    rx_oh = RX_VALID_IN && (RX_FIRST_IN || (!rpos.is_data && !rpos.is_zbit));
    next_rx_dv = rx_data;
    next_rx_done = RX_VALID_IN && !RX_FIRST_IN && rpos.pos == `HD2_RUN4_LAST;
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (!RST_N_IN)
    begin
      rx_dv <= 1'b0;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_dv <= next_rx_dv;
      rx_done <= next_rx_done;
    end
  end

  assign RX_DATA_VALID_OUT = rx_dv;
  assign RX_FRAME_DONE_OUT = rx_done;

  // same position map used for either direction
  for (genvar p = 0; p < NUM_PAIRS; p++)
  begin : g_rx_pair
    logic [`HD2_OH_RX_N-1:0] oh, next_oh;
    logic [`HD2_Z_N-1:0] z, next_z;
    logic d, next_d;
    logic acc, next_acc, err, next_err;
    logic [3:0] s_sel;

    always_comb
    begin
      s_sel = 4'(`HD2_SYNC_LEN - rx_idx);
      next_oh = oh;
      next_z = z;
      next_d = d;
      next_acc = acc;
      next_err = err;
      if (rx_data)
        next_d = RX_BIT_IN[p];
      if (rx_zbit)
        next_z[rpos.z_idx] = RX_BIT_IN[p];
      if (rx_oh && rx_idx != 6'h00 && rx_idx <= 6'(`HD2_OH_RX_N))
        next_oh[6'(rx_idx - 6'h01)] = RX_BIT_IN[p];
      // sync check across the fourteen bits
      if (rx_oh && rx_idx != 6'h00 && rx_idx <= `HD2_SYNC_LEN)
      begin
        next_acc = (RX_FIRST_IN ? 1'b0 : acc) |
          (RX_BIT_IN[p] != sync_pat[s_sel]);
        if (rx_idx == `HD2_SYNC_LEN)
          next_err = next_acc;
      end
    end

    always_ff @(posedge CLOCK_IN)
    begin
      if (!RST_N_IN)
      begin
        oh <= '1;
        z <= '1;
        d <= 1'b0;
        acc <= 1'b0;
        err <= 1'b0;
      end
      else
      begin
        oh <= next_oh;
        z <= next_z;
        d <= next_d;
        acc <= next_acc;
        err <= next_err;
      end
    end

    assign RX_DATA_OUT[p] = d;
    assign RX_OVERHEAD_OUT[p] = oh;
    assign RX_AUX_OVERHEAD_OUT[p] = z;
    assign RX_SYNC_ERR_OUT[p] = err;
  end
endmodule : hd2_framer

/* File: testbench/hd2_framer_monitor.sv */
/*
  Port checker for hd2_framer, bound into every instance.
  Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/1ns
`include "hd2_consts.svh"
module hd2_framer_monitor #(parameter int NUM_PAIRS = 2) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic ENABLE_IN,
  input wire logic DIR_REMOTE_IN,
  input wire logic LINE_VALID_OUT,
  input wire logic LINE_READY_IN,
  input wire logic [NUM_PAIRS-1:0] LINE_BIT_OUT,
  input wire logic LINE_FIRST_OUT,
  input wire logic FRAME_ACTIVE_OUT,
  input wire logic RX_VALID_IN,
  input wire logic RX_FIRST_IN,
  input wire logic [NUM_PAIRS-1:0] RX_BIT_IN,
  input wire logic RX_DATA_VALID_OUT,
  input wire logic [NUM_PAIRS-1:0] RX_DATA_OUT,
  input wire logic RX_FRAME_DONE_OUT
);
  localparam logic [13:0] SYNC = `HD2_SYNC_WORD;
  localparam logic [NUM_PAIRS-1:0] ONES = '1;
  logic [12:0] lp;
  logic [12:0] rp;
  logic [12:0] lc;
  logic [12:0] rc;
  logic rdat;
  function automatic logic dpos(input logic [12:0] q);
    logic [12:0] o;
    o = (q - 13'h11) % 13'h6d6;
    return q >= 13'h11 && q <= 13'h1b5e && o < 13'h6cc && o % 13'h91 != 13'h0;
  endfunction : dpos
  assign lc = LINE_FIRST_OUT ? 13'h1 : lp + 13'h1;
  assign rc = RX_FIRST_IN ? 13'h1 : rp + 13'h1;
  assign rdat = RX_VALID_IN && dpos(rc);
  // lp keeps the last frame's length until the next marker
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RST_N_IN)
    begin
      lp <= 13'h0;
      rp <= 13'h0;
    end
    else
    begin
      lp <= (LINE_VALID_OUT && LINE_READY_IN) ? lc : lp;
      rp <= RX_VALID_IN ? rc : rp;
    end
  end
  default clocking @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  sequence s_take;
    LINE_VALID_OUT && LINE_READY_IN;
  endsequence
  sequence s_held;
    LINE_VALID_OUT && $stable(LINE_BIT_OUT) && $stable(LINE_FIRST_OUT);
  endsequence
  a_reset_quiet_state: assert property (@(posedge CLOCK_IN) disable iff (1'b0)
    !RST_N_IN |=> !FRAME_ACTIVE_OUT && !LINE_VALID_OUT && !RX_DATA_VALID_OUT)
    else $error("outputs active after reset");
  a_line_hold_stall: assert property (
    LINE_VALID_OUT && !LINE_READY_IN |=> s_held)
    else $error("line word changed during stall");
  a_start_frame: assert property (
    !FRAME_ACTIVE_OUT && ENABLE_IN |=> FRAME_ACTIVE_OUT)
    else $error("enable did not start a frame");
  a_sync_word_bits: assert property (
    s_take ##0 (lc <= 13'he) |-> LINE_BIT_OUT == {NUM_PAIRS{SYNC[4'he - lc[3:0]]}})
    else $error("sync word bit wrong");
  a_frame_length: assert property (
    s_take ##0 LINE_FIRST_OUT |-> lp == 13'h0 || (lp >= 13'h1b5e && lp <= 13'h1b62 && !lp[0]))
    else $error("previous frame length illegal");
  a_spare_bits_one: assert property (
    s_take ##0 (lc > 13'h1b5e || lc == 13'h1491 || lc == 13'h1492) |-> LINE_BIT_OUT == ONES)
    else $error("spare or stuffing bit not one");
  a_power_toward_remote: assert property (
    s_take ##0 (!DIR_REMOTE_IN && (lc == 13'h6e3 || lc == 13'h6e4)) |-> LINE_BIT_OUT == ONES)
    else $error("power status sent toward remote");
  a_core_aux_one: assert property (
    s_take ##0 (lc >= 13'h11 && lc <= 13'h408 && (lc - 13'h11) % 13'h91 == 13'h0)
      |-> LINE_BIT_OUT == ONES)
    else $error("reserved aux bit not one");
  a_rx_data_out: assert property (
    rdat |=> RX_DATA_VALID_OUT && RX_DATA_OUT == $past(RX_BIT_IN))
    else $error("payload bit not delivered");
  a_rx_no_data: assert property (
    !rdat |=> !RX_DATA_VALID_OUT)
    else $error("data pulse on non-payload bit");
  a_rx_frame_done: assert property (
    RX_VALID_IN && rc == 13'h1b5e |=> RX_FRAME_DONE_OUT ##1 !RX_FRAME_DONE_OUT)
    else $error("frame done pulse wrong");
endmodule : hd2_framer_monitor

bind hd2_framer hd2_framer_monitor #(.NUM_PAIRS(NUM_PAIRS)) i_mon (.CLOCK_IN, .RST_N_IN,
  .ENABLE_IN, .DIR_REMOTE_IN, .LINE_VALID_OUT, .LINE_READY_IN, .LINE_BIT_OUT, .LINE_FIRST_OUT,
  .FRAME_ACTIVE_OUT, .RX_VALID_IN, .RX_FIRST_IN, .RX_BIT_IN, .RX_DATA_VALID_OUT,
  .RX_DATA_OUT, .RX_FRAME_DONE_OUT);

/* File: testbench/hd2_peer.sv */
/*
  Peer transceiver model: takes the line stream with random stalls and
  returns it one cycle later as the descrambled receive stream.
  Assumes the framer samples on the rising edge.
*/
`timescale 1ns/1ns
module hd2_peer #(parameter int NUM_PAIRS = 2) (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic corrupt_in,
  input wire logic line_valid_in,
  input wire logic line_first_in,
  input wire logic [NUM_PAIRS-1:0] line_bit_in,
  output logic line_ready_out = 1'b0,
  output logic rx_valid_out = 1'b0,
  output logic rx_first_out = 1'b0,
  output logic [NUM_PAIRS-1:0] rx_bit_out = '0
);
  // arbitrary seed, separate from the bench's
  int seed = 32'h2c61_05d7;
  int pos = 0;
  logic tk = 1'b0;
  logic f;
  logic [NUM_PAIRS-1:0] b;
  always @(posedge clk_in)
  begin
    tk = line_valid_in && line_ready_out;
    f = line_first_in;
    b = line_bit_in;
  end
  always @(negedge clk_in)
  begin
    line_ready_out <= !stall_in && 2'($random(seed)) != 2'h0;
    pos = tk ? (f ? 1 : pos + 1) : pos;
    // idle line toggles so a stale bit never looks valid
    rx_bit_out <= tk ? b ^ NUM_PAIRS'(corrupt_in && pos == 3) : ~rx_bit_out;
    rx_valid_out <= tk;
    rx_first_out <= tk && f;
  end
endmodule : hd2_peer

/* File: testbench/test_hd2_framer.sv */
/*
  Bench for hd2_framer: random payload and overhead, peer stalls, and the
  line stream looped back into the receive side.
  Assumes the checker and the peer model are compiled first.
*/
`timescale 1ns/1ns
`include "hd2_consts.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end
module test_hd2_framer;
  import hd2_pkg::*;
  int seed = 32'h93ffeb9b;
  int error_cnt = 0;
  int check_count = 0;
  int frames = 0;
  int cyc = 0;
  int lp = 0;
  int q = 0;
  logic clk, dir, regen, losd, alarm, rtr, pr, lv, lr, lf, act, rv, rf, rdv, rdone;
  logic rst_n = 1'b0, en = 1'b0, pv = 1'b0, stall = 1'b0, bad = 1'b0;
  hd2_stuff_t stuff;
  logic [1:0] febe, bpv, ps, lb, rxb, rdo, rse, e;
  logic [1:0] pd = 2'h0;
  logic [3:0] rgb;
  logic [12:0] eoc;
  logic [1:0][5:0] crc;
  logic [1:0][39:0] aux;
  logic [1:0][45:0] roh;
  logic [1:0][47:0] rax;
  logic [1:0] tq[$];
  logic [1:0] rq[$];
  hd2_framer #(.NUM_PAIRS(2)) i_dut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .DIR_REMOTE_IN(dir), .REGEN_IN(regen), .ENABLE_IN(en),
    .STUFF_PAIRS_IN(stuff), .LOSD_IN(losd), .FEBE_IN(febe), .BPV_IN(bpv), .CRC_IN(crc),
    .EOC_IN(eoc), .UNIT_POWER_STATUS_IN(ps), .REMOTE_ALARM_IN(alarm),
    .READY_TO_RECEIVE_IN(rtr), .REGEN_BITS_IN(rgb), .AUX_OVERHEAD_IN(aux),
    .PAYLOAD_VALID_IN(pv), .PAYLOAD_READY_OUT(pr), .PAYLOAD_DATA_IN(pd),
    .LINE_VALID_OUT(lv), .LINE_READY_IN(lr), .LINE_BIT_OUT(lb), .LINE_FIRST_OUT(lf),
    .FRAME_ACTIVE_OUT(act), .RX_VALID_IN(rv), .RX_FIRST_IN(rf), .RX_BIT_IN(rxb),
    .RX_DATA_VALID_OUT(rdv), .RX_DATA_OUT(rdo), .RX_OVERHEAD_OUT(roh),
    .RX_AUX_OVERHEAD_OUT(rax), .RX_SYNC_ERR_OUT(rse), .RX_FRAME_DONE_OUT(rdone));
  hd2_peer #(.NUM_PAIRS(2)) i_peer (.clk_in(clk), .stall_in(stall), .corrupt_in(bad),
    .line_valid_in(lv), .line_first_in(lf), .line_bit_in(lb), .line_ready_out(lr),
    .rx_valid_out(rv), .rx_first_out(rf), .rx_bit_out(rxb));

  function automatic logic isd(input int q);
    int o;
    o = (q - 17) % 1750;
    return q >= 17 && q <= 7006 && o < 1740 && o % 145 != 0;
  endfunction : isd

  // expected frame bit at position q on pair p, payload excluded
  function automatic logic ebit(input int q, input int p);
    int r;
    int o;
    int h;
    logic [13:0] pat;
    pat = `HD2_SYNC_WORD;
    r = (q - 17) / 1750;
    o = (q - 17) % 1750;
    h = 17 + 10 * r + o - 1740;
    if (q <= 14)
      return pat[14 - q];
    if (q == 15 || q == 16)
      return (q == 15) ? losd : febe[p];
    if (q > 7006)
      return 1'b1;
    if (o < 1740)
      return (r * 12 + o / 145 < 8) ? 1'b1 : aux[p][r * 12 + o / 145 - 8];
    case (h)
      17, 18, 19, 20: return eoc[h - 17];
      21, 22: return crc[p][h - 21];
      23, 24: return dir ? ps[h - 23] : 1'b1;
      25: return bpv[p];
      26: return eoc[4];
      27, 28, 29, 30: return eoc[h - 22];
      31, 32: return crc[p][h - 29];
      33, 34, 35, 36: return regen ? rgb[h - 33] : 1'b1;
      37, 38, 39, 40: return eoc[h - 28];
      41, 42: return crc[p][h - 37];
      43: return dir ? alarm : 1'b1;
      44: return rtr;
      default: return 1'b1;
    endcase
  endfunction : ebit

  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic setup(input logic d, g, input hd2_stuff_t s, input logic c);
    dir = d;
    regen = g;
    stuff = s;
    bad = c;
    {losd, febe, bpv, ps, alarm, rtr, rgb} = 13'($random(seed));
    crc = 12'($random(seed));
    eoc = 13'($random(seed));
    aux = {$random(seed), $random(seed), 16'($random(seed))};
  endtask : setup

  task automatic run_frame(input logic d, g, input hd2_stuff_t s, input logic c);
    int n;
    n = frames;
    setup(d, g, s, c);
    en = 1'b1;
    @(negedge clk);
    en = 1'b0;
    if (!d && !c)
    begin
      // stall on an open payload slot, else ready is low anyway
      while (!pr)
        @(negedge clk);
      stall = 1'b1;
      repeat (20) @(negedge clk);
      `CHK("payload ready when full", 1'b0, pr)
      stall = 1'b0;
    end
    while (frames == n || act || lv)
      @(negedge clk);
    `CHK("frame length", 7006 + 2 * ((s > 2) ? 2 : int'(s)), lp)
  endtask : run_frame

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge clk)
  begin
    pv <= rst_n && 2'($random(seed)) != 2'h0;
    pd <= 2'($random(seed));
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      error_cnt++;
      end_of_test();
    end
    if (rst_n && lv && lr)
    begin
      lp = lf ? 1 : lp + 1;
      e = isd(lp) ? tq.pop_front() : {ebit(lp, 1), ebit(lp, 0)};
      `CHK("line bit", e, lb)
    end
    if (pv && pr)
    begin
      tq.push_back(pd);
      rq.push_back(pd);
    end
    if (rdv)
    begin
      e = rq.pop_front();
      `CHK("rx payload", e, rdo)
    end
    if (rdone)
    begin
      for (int p = 0; p < 2; p++)
      begin
        for (int i = 15; i <= 46; i++)
        begin
          q = (i <= 16) ? i : 1757 + 1750 * ((i - 17) / 10) + (i - 17) % 10;
          `CHK("rx overhead", ebit(q, p), roh[p][i - 1])
        end
        for (int n = 1; n <= 48; n++)
        begin
          q = 17 + 1750 * ((n - 1) / 12) + 145 * ((n - 1) % 12);
          `CHK("rx aux", ebit(q, p), rax[p][n - 1])
        end
      end
      `CHK("sync check", {1'b0, bad}, rse)
      frames++;
    end
  end

  initial
  begin
    setup(1'b0, 1'b0, 2'h0, 1'b0);
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    `CHK("reset state", 3'h0, {act, lv, pr})
    `CHK("reset overhead", {92{1'b1}}, roh)
    run_frame(1'b0, 1'b0, 2'h1, 1'b0);
    run_frame(1'b1, 1'b1, 2'h0, 1'b1);
    run_frame(1'b1, 1'b0, 2'h3, 1'b0);
    end_of_test();
  end
endmodule : test_hd2_framer
